// ===== bench/sfs_supervisor_asserts.sv
// Port checker for the field bus fault supervisor.
module sfs_supervisor_asserts
  import sfs_pkg::*;
#(
  parameter int GAP_CYCLES = RESET_GAP_CYC
) (
  input wire logic                 CLK_SYS,
  input wire logic                 RST_N,
  input wire logic                 S_AXI_BVALID,
  input wire logic                 S_AXI_BREADY,
  input wire logic [NUM_UNITS-1:0] UNIT_POLL_EN,
  input wire logic [1:0]           TERM_LAYOUT,
  input wire logic [NUM_DET-1:0]   DET_EVENT,
  input wire logic [NUM_DET-1:0]   DET_RESET,
  input wire logic                 PERM_FAULT,
  input wire logic                 FLASH_REQ,
  input wire logic [79:0]          MON_MAP
);
  timeunit 1ns;
  timeprecision 1ps;
  int   gap_q, gap_d;
  logic map_ok;
  // Counts cycles since the last reset pulse of detector zero.
  always_comb begin
    gap_d = (gap_q < GAP_CYCLES) ? gap_q + 1 : gap_q;
    if (DET_RESET[0]) gap_d = 0;
  end
  // Starts saturated so the first pulse after reset is allowed.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) gap_q <= GAP_CYCLES;
    else gap_q <= gap_d;
  end
  // Flags a monitor channel that points outside output channels 1 to 24.
  always_comb begin
    map_ok = 1'h1;
    for (int c = 0; c < 16; c++) begin
      if (MON_MAP[5*c+:5] == 5'h00 || MON_MAP[5*c+:5] > 5'h18) map_ok = 1'h0;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);
  property p_poll_rsvd; UNIT_POLL_EN[7:4] == 4'h0; endproperty
  a_poll_rsvd: assert property (p_poll_rsvd)
    else $error("Reserved terminal slot is polled.");
  property p_layout; TERM_LAYOUT != 2'h3; endproperty
  a_layout: assert property (p_layout)
    else $error("Layout code is out of range.");
  property p_flash; PERM_FAULT == FLASH_REQ; endproperty
  a_flash: assert property (p_flash)
    else $error("Flash request does not follow permissive fault.");
  property p_map; $past(RST_N) |-> map_ok; endproperty
  a_map: assert property (p_map)
    else $error("Monitor map holds a zero or too large channel.");
  property p_evt; DET_EVENT[0] |=> !DET_EVENT[0]; endproperty
  a_evt: assert property (p_evt)
    else $error("Detector event is longer than one cycle.");
  property p_rst; DET_RESET[0] |=> !DET_RESET[0]; endproperty
  a_rst: assert property (p_rst)
    else $error("Detector reset is longer than one cycle.");
  property p_gap; DET_RESET[0] |-> gap_q >= GAP_CYCLES - 1; endproperty
  a_gap: assert property (p_gap)
    else $error("Detector reset pulses are too close.");
  property p_bhold; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID; endproperty
  a_bhold: assert property (p_bhold)
    else $error("Write response stayed after it was taken.");
endmodule : sfs_supervisor_asserts

// ===== bench/sfs_supervisor_tb.sv
// Self-checking bench for the field bus fault supervisor.
module sfs_supervisor_tb
  import sfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MIN_CYC = 20;
  localparam int GAP_CYC = 10;
  logic                 clk_sys, rst_n, crit, perm_f, flash;
  logic [7:0]           awaddr, araddr;
  logic [31:0]          wdata, rdata, rd_q;
  logic [1:0]           bresp, rresp, layout;
  logic                 awvalid, wvalid, bready, arvalid, rready;
  logic                 awready, wready, bvalid, arready, rvalid;
  logic [NUM_UNITS-1:0] link_ok, frame_err, poll_en, drop, err_go;
  logic [NUM_DET-1:0]   det_fault, det_wdog, det_event, det_reset;
  logic [119:0]         card_perm;
  logic [79:0]          mon_map;
  int                   num_errors, cmp_count, n_evt, n_rst;
  // Design with shortened minute and reset spacing counts.
  sfs_supervisor #(.MINUTE_CYCLES(MIN_CYC), .GAP_CYCLES(GAP_CYC))
  i_sfs_supervisor (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .UNIT_LINK_OK(link_ok),
    .UNIT_FRAME_ERR(frame_err), .DET_FAULT(det_fault), .DET_WDOG(det_wdog),
    .MON_CARD_PERM(card_perm), .UNIT_POLL_EN(poll_en),
    .TERM_LAYOUT(layout), .DET_EVENT(det_event), .DET_RESET(det_reset),
    .CRIT_FAULT(crit), .PERM_FAULT(perm_f), .FLASH_REQ(flash),
    .MON_MAP(mon_map)
  );
  sfs_unit_model i_sfs_unit_model (
    .clk_sys(clk_sys), .drop(drop), .err_go(err_go), .link_ok(link_ok),
    .frame_err(frame_err)
  );
  ////////////////////////////////////////
  // Free running system clock.
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Counts pulses of detector zero away from the clock edge.
  always @(negedge clk_sys) begin
    n_evt += int'(det_event[0]);
    n_rst += int'(det_reset[0]);
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task automatic final_report;
    $display("Mismatches %0d of %0d compares", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One AXI4-Lite write or read; holds each channel until it is taken.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [1:0] er);
    logic       ta, tw, dn;
    logic [1:0] rs;
    dn = 1'h0;
    @(posedge clk_sys);
    if (w) begin
      {awaddr, wdata} <= {a, d};
      {awvalid, wvalid, bready} <= 3'h7;
    end else begin
      araddr <= a;
      {arvalid, rready} <= 2'h3;
    end
    for (int n = 0; n < 40 && !dn; n++) begin
      @(negedge clk_sys);
      ta = w ? awvalid & awready : arvalid & arready;
      tw = wvalid & wready;
      dn = w ? bvalid : rvalid;
      rs = w ? bresp : rresp;
      rd_q = rdata;
      @(posedge clk_sys);
      if (ta && w) awvalid <= 1'h0;
      if (ta && !w) arvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end
    {bready, rready} <= 2'h0;
    if (!dn) begin
      num_errors++;
      final_report();
    end
    chk("resp", er, rs);
  endtask : xfer
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    xfer(1'h0, a, 32'h0, RESP_OKAY);
    chk(nm, e, rd_q);
  endtask : rchk
  // Drops one unit, checks the fault, restores it and checks the expected fault state.
  task automatic flt(input int u, input logic e);
    drop[u] <= 1'h1;
    cyc(8);
    chk("crit", 1, crit);
    drop[u] <= 1'h0;
    cyc(8);
    chk("crit_after", e, crit);
  endtask : flt
  ////////////////////////////////////////
  // Main sequence.
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr} = '0;
    {wdata, drop, err_go, det_fault, det_wdog, card_perm} = '0;
    {num_errors, cmp_count, n_evt, n_rst} = '0;
    rst_n = 1'h0;
    cyc(5);
    rst_n <= 1'h1;
    cyc(2);
    chk("poll", 0, poll_en);
    chk("map0", 1, mon_map[4:0]);
    xfer(1'h1, ADDR_ENABLE, 32'h0001FFFF, RESP_OKAY);
    xfer(1'h1, ADDR_CTRL, 32'h00000001, RESP_OKAY);
    cyc(4);
    chk("poll", 32'h0001FF0F, poll_en);
    rchk("enable", ADDR_ENABLE, 32'h0001FF0F);
    rchk("link", ADDR_LINK, 32'h0001FFFF);
    xfer(1'h0, ADDR_PERM, 32'h0, RESP_SLVERR);
    xfer(1'h0, 8'h3C, 32'h0, RESP_SLVERR);
    for (int m = 0; m < 4; m++) begin
      xfer(1'h1, ADDR_CTRL, 32'(1 + 2 * m), m < 3 ? RESP_OKAY : RESP_SLVERR);
      cyc(4);
      chk("layout", m < 3 ? m : 2, layout);
    end
    xfer(1'h1, ADDR_CTRL, 32'h00000001, RESP_OKAY);
    flt(2, 1'h1);
    xfer(1'h1, ADDR_CLEAR, 32'h00000001, RESP_OKAY);
    cyc(4);
    chk("crit_clr", 0, crit);
    xfer(1'h1, ADDR_CTRL, 32'h00000301, RESP_OKAY);
    flt(9, 1'h0);
    flt(9, 1'h0);
    flt(9, 1'h1);
    xfer(1'h1, ADDR_CLEAR, 32'h00000001, RESP_OKAY);
    cyc(100);
    flt(9, 1'h0);
    cyc(100);
    flt(9, 1'h0);
    flt(9, 1'h0);
    for (int m = 0; m < 3; m++) begin
      xfer(1'h1, ADDR_CTRL, 32'(1 + 8 * m), RESP_OKAY);
      {n_evt, n_rst} = '0;
      {det_fault[0], det_wdog[0]} <= 2'h3;
      cyc(45);
      {det_fault[0], det_wdog[0]} <= 2'h0;
      cyc(6);
      chk("events", m > 0, n_evt);
      chk("resets", m == 2, n_rst inside {[4:5]});
      if (m < 2) chk("no_reset", 0, n_rst);
    end
    card_perm <= {24'hFFFFFF, 96'h20};
    cyc(6);
    chk("perm", 1, perm_f);
    chk("flash", 1, flash);
    xfer(1'h1, ADDR_PERMDAT, 32'h00000020, RESP_OKAY);
    xfer(1'h1, ADDR_PERMSEL, 32'h00000003, RESP_OKAY);
    xfer(1'h1, ADDR_PERMDAT, 32'hFFFFFFFF, RESP_OKAY);
    cyc(6);
    chk("perm", 0, perm_f);
    rchk("permdat3", ADDR_PERMDAT, 32'h00FFFFFF);
    xfer(1'h1, ADDR_ERRSEL, 32'h00000003, RESP_OKAY);
    xfer(1'h1, ADDR_MMAP, 32'h00000318, RESP_OKAY);
    cyc(4);
    chk("map3", 32'h18, mon_map[19:15]);
    rchk("mmap", ADDR_MMAP, 32'h00000018);
    xfer(1'h1, ADDR_MMAP, 32'h00000300, RESP_OKAY);
    xfer(1'h1, ADDR_MMAP, 32'h00000319, RESP_SLVERR);
    cyc(4);
    chk("map3_id", 32'h4, mon_map[19:15]);
    xfer(1'h1, ADDR_ERRSEL, 32'h00000009, RESP_OKAY);
    repeat (2) begin
      err_go[9] <= 1'h1;
      cyc(1);
      err_go[9] <= 1'h0;
      cyc(6);
    end
    rchk("errcnt", ADDR_ERRCNT, 32'h00000002);
    xfer(1'h0, ADDR_STATUS, 32'h0, RESP_OKAY);
    chk("stat9", 1, rd_q[9]);
    xfer(1'h1, ADDR_CLEAR, 32'h00000002, RESP_OKAY);
    rchk("errcnt_clr", ADDR_ERRCNT, 32'h0);
    xfer(1'h0, ADDR_STATUS, 32'h0, RESP_OKAY);
    chk("stat9_clr", 0, rd_q[9]);
    final_report();
  end
  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    final_report();
  end
endmodule : sfs_supervisor_tb
bind sfs_supervisor sfs_supervisor_asserts #(.GAP_CYCLES(GAP_CYCLES))
  i_sfs_supervisor_asserts (
  .CLK_SYS, .RST_N, .S_AXI_BVALID, .S_AXI_BREADY, .UNIT_POLL_EN,
  .TERM_LAYOUT, .DET_EVENT, .DET_RESET, .PERM_FAULT, .FLASH_REQ, .MON_MAP
);

// ===== bench/sfs_unit_model.sv
// Remote unit model: answering links and timed frame error bursts.
module sfs_unit_model
  import sfs_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic [NUM_UNITS-1:0] drop,
  input  wire logic [NUM_UNITS-1:0] err_go,
  output logic      [NUM_UNITS-1:0] link_ok,
  output logic      [NUM_UNITS-1:0] frame_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NUM_UNITS-1:0] err_h1;
  logic [NUM_UNITS-1:0] err_h2;
  // A dropped unit stops answering; a request gives a three cycle error.
  always_ff @(posedge clk_sys) begin
    link_ok   <= ~drop;
    err_h1    <= err_go;
    err_h2    <= err_h1;
    frame_err <= err_go | err_h1 | err_h2;
  end
endmodule : sfs_unit_model

// ===== hdl/sfs_gap_timer.sv
// Per-detector spacing timer for automatic detector reset pulses.
module sfs_gap_timer
  import sfs_pkg::*;
#(
  parameter int GAP_CYC = RESET_GAP_CYC
) (
  input  wire logic CLK_SYS,
  input  wire logic RST_N,
  input  wire logic enable,
  input  wire logic wdog,
  output logic      pulse
);
  localparam int CW = $clog2(GAP_CYC + 1);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          pulse_d;

  // A pulse fires only once the gap since the previous pulse has run out.
  always_comb begin
    cnt_d   = cnt_q;
    pulse_d = 1'b0;
    if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end else if (enable && wdog) begin
      pulse_d = 1'b1;
      cnt_d   = CW'(GAP_CYC - 1);
    end
  end

  // Registers the countdown and the reset pulse.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cnt_q <= '0;
      pulse <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      pulse <= pulse_d;
    end
  end
endmodule : sfs_gap_timer

// ===== hdl/sfs_pkg.sv
// Package of constants and types for the field bus fault supervisor.
package sfs_pkg;
  localparam int NUM_UNITS       = 17;
  localparam int NUM_TERM        = 8;
  localparam int NUM_DET         = 8;
  localparam int TERM_DEFINED    = 4;
  localparam int UNIT_MON        = 16;
  localparam int CLK_HZ          = 20_000_000;
  localparam int RESET_GAP_S     = 20;
  localparam int RESET_GAP_CYC   = CLK_HZ * RESET_GAP_S;
  localparam int MINUTE_S        = 60;
  localparam int MINUTE_CYC      = CLK_HZ * MINUTE_S;
  localparam int BUS_BPS_X10     = 1536000;
  localparam int ERRCNT_W        = 8;
  localparam int FAULT_LATCH_CNT = 3;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_ENABLE  = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_CLEAR   = 8'h0C;
  localparam logic [7:0] ADDR_LINK    = 8'h10;
  localparam logic [7:0] ADDR_PERM    = 8'h14;
  localparam logic [7:0] ADDR_MMAP    = 8'h18;
  localparam logic [7:0] ADDR_ERRSEL  = 8'h1C;
  localparam logic [7:0] ADDR_ERRCNT  = 8'h20;
  localparam logic [7:0] ADDR_PERMSEL = 8'h24;
  localparam logic [7:0] ADDR_PERMDAT = 8'h28;

  // Control register fields.
  localparam int CTRL_RUN     = 0;
  localparam int CTRL_MAP_LO  = 1;
  localparam int CTRL_DET_LO  = 3;
  localparam int CTRL_RETRY_LO = 8;

  // Clear register bits.
  localparam int CLR_FAULT = 0;
  localparam int CLR_ERRS  = 1;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    SFS_MAP_16 = 2'h0,
    SFS_MAP_24 = 2'h1,
    SFS_MAP_SINGLE = 2'h2
  } sfs_map_t;

  typedef enum logic [1:0] {
    SFS_DET_OFF = 2'h0,
    SFS_DET_ON  = 2'h1,
    SFS_DET_RST = 2'h2
  } sfs_det_t;

  typedef enum logic [2:0] {
    SFS_OK      = 3'b001,
    SFS_HOLD    = 3'b010,
    SFS_LATCHED = 3'b100
  } sfs_fault_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
  } sfs_wr_t;
endpackage : sfs_pkg

// ===== hdl/sfs_supervisor.sv
// Field bus fault supervisor with an AXI4-Lite register slave.
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - The field bus runs synchronously at 153.6 Kbps with standard frames.
// - Frames flow to every enabled unit at once while run is on.
// - Seventeen unit slots: eight terminal, eight detector, one monitor.
// - Terminal units five to eight are reserved and never enabled.
// - Map setting picks 16, 24 or single-unit 8 channel layout.
// - A 0 to 255 minute retry time loads the fault countdown.
// - Retry time zero latches every critical fault until cleared.
// - Nonzero retry holds fault only until links return; countdown continues.
// - Third fault inside one countdown latches until cleared.
// - Detector fault setting gates detector event recording.
// - On-with-reset issues a detector reset on watchdog fault.
// - Automatic detector resets stay at least 20 seconds apart.
// - Permissive table mismatch with monitor card gives fault and flash.
// - Permissive table is a triangular matrix over channels 1-16.
// - Each monitor channel maps to an output channel; 0 means identity.
// - Per unit frame error count, and lost-link status for units 1 to 16, readable and clearable.
// - Lost link to an enabled unit raises a critical fault.
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
module sfs_supervisor
  import sfs_pkg::*;
#(
  parameter int MINUTE_CYCLES = MINUTE_CYC,
  parameter int GAP_CYCLES    = RESET_GAP_CYC
) (
  input  wire logic                 CLK_SYS,
  input  wire logic                 RST_N,
  input  wire logic [7:0]           S_AXI_AWADDR,
  input  wire logic                 S_AXI_AWVALID,
  output logic                      S_AXI_AWREADY,
  input  wire logic [31:0]          S_AXI_WDATA,
  input  wire logic [3:0]           S_AXI_WSTRB,
  input  wire logic                 S_AXI_WVALID,
  output logic                      S_AXI_WREADY,
  output logic [1:0]                S_AXI_BRESP,
  output logic                      S_AXI_BVALID,
  input  wire logic                 S_AXI_BREADY,
  input  wire logic [7:0]           S_AXI_ARADDR,
  input  wire logic                 S_AXI_ARVALID,
  output logic                      S_AXI_ARREADY,
  output logic [31:0]               S_AXI_RDATA,
  output logic [1:0]                S_AXI_RRESP,
  output logic                      S_AXI_RVALID,
  input  wire logic                 S_AXI_RREADY,
  input  wire logic [NUM_UNITS-1:0] UNIT_LINK_OK,
  input  wire logic [NUM_UNITS-1:0] UNIT_FRAME_ERR,
  input  wire logic [NUM_DET-1:0]   DET_FAULT,
  input  wire logic [NUM_DET-1:0]   DET_WDOG,
  input  wire logic [119:0]         MON_CARD_PERM,
  output logic [NUM_UNITS-1:0]      UNIT_POLL_EN,
  output logic [1:0]                TERM_LAYOUT,
  output logic [NUM_DET-1:0]        DET_EVENT,
  output logic [NUM_DET-1:0]        DET_RESET,
  output logic                      CRIT_FAULT,
  output logic                      PERM_FAULT,
  output logic                      FLASH_REQ,
  output logic [79:0]               MON_MAP
);
  localparam int PERM_BITS = 120;
  localparam int MW = $clog2(MINUTE_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for the unit status pins.
  logic [NUM_UNITS-1:0] link_s1_q, link_s2_q, ferr_s1_q, ferr_s2_q, ferr_s3_q;
  logic [NUM_DET-1:0]   dflt_s1_q, dflt_s2_q, dflt_s3_q, wdog_s1_q, wdog_s2_q;
  logic [PERM_BITS-1:0] card_s1_q, card_s2_q;

  // Two flops on every pin, a third for edge detection where needed.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      link_s1_q <= '1;
      link_s2_q <= '1;
      ferr_s1_q <= '0;
      ferr_s2_q <= '0;
      ferr_s3_q <= '0;
      dflt_s1_q <= '0;
      dflt_s2_q <= '0;
      dflt_s3_q <= '0;
      wdog_s1_q <= '0;
      wdog_s2_q <= '0;
      card_s1_q <= '0;
      card_s2_q <= '0;
    end else begin
      link_s1_q <= UNIT_LINK_OK;
      link_s2_q <= link_s1_q;
      ferr_s1_q <= UNIT_FRAME_ERR;
      ferr_s2_q <= ferr_s1_q;
      ferr_s3_q <= ferr_s2_q;
      dflt_s1_q <= DET_FAULT;
      dflt_s2_q <= dflt_s1_q;
      dflt_s3_q <= dflt_s2_q;
      wdog_s1_q <= DET_WDOG;
      wdog_s2_q <= wdog_s1_q;
      card_s1_q <= MON_CARD_PERM;
      card_s2_q <= card_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bank and AXI4-Lite slave.
  logic [31:0]          ctrl_q, ctrl_d;
  logic [NUM_UNITS-1:0] enable_q, enable_d;
  logic [PERM_BITS-1:0] perm_q, perm_d;
  logic [79:0]          mmap_q, mmap_d;
  logic [4:0]           errsel_q, errsel_d;
  logic [2:0]           permsel_q, permsel_d;
  logic                 aw_q, aw_d, w_q, w_d;
  logic [7:0]           awaddr_q, awaddr_d;
  logic [31:0]          wdata_q, wdata_d;
  logic                 bvalid_d, rvalid_d;
  logic [1:0]           bresp_d, rresp_d;
  logic [31:0]          rdata_d;
  logic                 clr_fault, clr_errs, do_wr, map_ok;
  sfs_wr_t              wr;
  logic [31:0]          status_w;
  logic [ERRCNT_W-1:0]  errcnt [NUM_UNITS];

  assign S_AXI_AWREADY = !aw_q && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_q && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign wr = '{addr: awaddr_q, data: wdata_q};
  assign do_wr = aw_q && w_q && !S_AXI_BVALID;
  // Terminal layout codes outside the three layouts are refused.
  assign map_ok = wdata_q[CTRL_MAP_LO +: 2] != 2'h3;

  // Address and data are caught in any order; the write lands once both are.
  always_comb begin
    ctrl_d    = ctrl_q;
    enable_d  = enable_q;
    perm_d    = perm_q;
    mmap_d    = mmap_q;
    errsel_d  = errsel_q;
    permsel_d = permsel_q;
    aw_d      = aw_q;
    w_d       = w_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    bvalid_d  = S_AXI_BVALID && !S_AXI_BREADY;
    bresp_d   = S_AXI_BRESP;
    rvalid_d  = S_AXI_RVALID && !S_AXI_RREADY;
    rresp_d   = S_AXI_RRESP;
    rdata_d   = S_AXI_RDATA;
    clr_fault = 1'b0;
    clr_errs  = 1'b0;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_d     = 1'b1;
      awaddr_d = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_d     = 1'b1;
      wdata_d = S_AXI_WDATA;
    end
    if (do_wr) begin
      aw_d     = 1'b0;
      w_d      = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = RESP_OKAY;
      unique case (wr.addr)
        ADDR_CTRL: begin
          if (map_ok) begin
            ctrl_d = wr.data;
          end else begin
            bresp_d = RESP_SLVERR;
          end
        end
        ADDR_ENABLE: begin
          enable_d = wr.data[NUM_UNITS-1:0];
          // Reserved terminal slots cannot be enabled.
          enable_d[NUM_TERM-1:TERM_DEFINED] = '0;
        end
        ADDR_CLEAR: begin
          clr_fault = wr.data[CLR_FAULT];
          clr_errs  = wr.data[CLR_ERRS];
        end
        ADDR_PERMSEL: permsel_d = {1'b0, wr.data[1:0]};
        ADDR_PERMDAT: begin
          if (permsel_q == 3'h3) begin
            perm_d[96 +: 24] = wr.data[23:0];
          end else begin
            perm_d[permsel_q*32 +: 32] = wr.data;
          end
        end
        ADDR_MMAP: begin
          // Entry index in [11:8]; channels above 24 are refused.
          if (wr.data[4:0] > 5'h18) bresp_d = RESP_SLVERR;
          else mmap_d[wr.data[11:8]*5 +: 5] = wr.data[4:0];
        end
        ADDR_ERRSEL: errsel_d = wr.data[4:0];
        default: bresp_d = RESP_SLVERR;
      endcase
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      unique case (S_AXI_ARADDR)
        ADDR_CTRL:    rdata_d = ctrl_q;
        ADDR_ENABLE:  rdata_d = 32'(enable_q);
        ADDR_STATUS:  rdata_d = status_w;
        ADDR_LINK:    rdata_d = 32'(link_s2_q);
        ADDR_ERRSEL:  rdata_d = 32'(errsel_q);
        ADDR_ERRCNT:  rdata_d = (errsel_q < 5'(NUM_UNITS)) ?
                                32'(errcnt[errsel_q]) : 32'h0;
        ADDR_PERMSEL: rdata_d = 32'(permsel_q);
        ADDR_PERMDAT: rdata_d = (permsel_q == 3'h3) ? 32'(perm_q[96 +: 24])
                                : perm_q[permsel_q*32 +: 32];
        ADDR_MMAP:    rdata_d = 32'(mmap_q[errsel_q[3:0]*5 +: 5]);
        ADDR_CLEAR:   rdata_d = 32'h0;
        default: begin
          rdata_d = 32'h0;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  // Registers of the bus slave and the software settings.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q       <= 32'h0;
      enable_q     <= '0;
      perm_q       <= '0;
      mmap_q       <= '0;
      errsel_q     <= '0;
      permsel_q    <= '0;
      aw_q         <= 1'b0;
      w_q          <= 1'b0;
      awaddr_q     <= '0;
      wdata_q      <= '0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= RESP_OKAY;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RRESP  <= RESP_OKAY;
      S_AXI_RDATA  <= 32'h0;
    end else begin
      ctrl_q       <= ctrl_d;
      enable_q     <= enable_d;
      perm_q       <= perm_d;
      mmap_q       <= mmap_d;
      errsel_q     <= errsel_d;
      permsel_q    <= permsel_d;
      aw_q         <= aw_d;
      w_q          <= w_d;
      awaddr_q     <= awaddr_d;
      wdata_q      <= wdata_d;
      S_AXI_BVALID <= bvalid_d;
      S_AXI_BRESP  <= bresp_d;
      S_AXI_RVALID <= rvalid_d;
      S_AXI_RRESP  <= rresp_d;
      S_AXI_RDATA  <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field settings decoded from the control register.
  logic       run;
  logic [7:0] retry_min;
  sfs_det_t   det_mode;
  assign run       = ctrl_q[CTRL_RUN];
  assign retry_min = ctrl_q[CTRL_RETRY_LO +: 8];
  assign det_mode  = sfs_det_t'(ctrl_q[CTRL_DET_LO +: 2]);

  ////////////////////////////////////////////////////////////////////////////
  // Critical fault supervisor with retry countdown.
  sfs_fault_t     fst_q, fst_d;
  logic [7:0]     mins_q, mins_d;
  logic [MW-1:0]  tick_q, tick_d;
  logic [1:0]     nflt_q, nflt_d;
  logic           lost, lost_q, new_fault, counting;

  // A link is lost when an enabled, polled unit stops answering.
  assign lost      = run && |(UNIT_POLL_EN & ~link_s2_q);
  assign new_fault = lost && !lost_q;
  assign counting  = mins_q != 8'h0;

  // Next state of the fault state machine and the countdown.
  always_comb begin
    fst_d  = fst_q;
    mins_d = mins_q;
    tick_d = tick_q;
    nflt_d = nflt_q;
    if (counting) begin
      tick_d = (tick_q == MW'(MINUTE_CYCLES - 1)) ? '0 : tick_q + 1'b1;
      if (tick_q == MW'(MINUTE_CYCLES - 1)) begin
        mins_d = mins_q - 8'h1;
        if (mins_q == 8'h1) begin
          nflt_d = 2'h0;
        end
      end
    end
    unique case (fst_q)
      SFS_OK: begin
        if (new_fault) begin
          if (retry_min == 8'h0) begin
            fst_d = SFS_LATCHED;
          end else begin
            fst_d  = SFS_HOLD;
            nflt_d = nflt_q + 2'h1;
            if (!counting) begin
              mins_d = retry_min;
              tick_d = '0;
              nflt_d = 2'h1;
            end else if (nflt_q == 2'(FAULT_LATCH_CNT - 1)) begin
              fst_d = SFS_LATCHED;
            end
          end
        end
      end
      SFS_HOLD: begin
        if (!lost) begin
          fst_d = SFS_OK;
        end
      end
      SFS_LATCHED: ;
      default: fst_d = SFS_LATCHED;
    endcase
    if (clr_fault && !new_fault) begin
      fst_d  = SFS_OK;
      nflt_d = 2'h0;
      mins_d = 8'h0;
    end
  end

  // Registers of the fault supervisor.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      fst_q  <= SFS_OK;
      mins_q <= 8'h0;
      tick_q <= '0;
      nflt_q <= 2'h0;
      lost_q <= 1'b0;
    end else begin
      fst_q  <= fst_d;
      mins_q <= mins_d;
      tick_q <= tick_d;
      nflt_q <= nflt_d;
      lost_q <= lost;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame error counters and sticky per-unit status.
  logic [NUM_UNITS-1:0] ustat_q, ustat_d;
  logic [ERRCNT_W-1:0]  ecnt_q [NUM_UNITS];
  logic [ERRCNT_W-1:0]  ecnt_d [NUM_UNITS];
  logic [NUM_UNITS-1:0] ferr_ev;
  assign ferr_ev = ferr_s2_q & ~ferr_s3_q & UNIT_POLL_EN;

  // Counts saturate; a new error in the clearing cycle survives.
  always_comb begin
    ustat_d = ustat_q & ~({NUM_UNITS{clr_errs}});
    ustat_d = ustat_d | (UNIT_POLL_EN & ~link_s2_q);
    for (int i = 0; i < NUM_UNITS; i++) begin
      ecnt_d[i] = clr_errs ? '0 : ecnt_q[i];
      if (ferr_ev[i] && ecnt_d[i] != '1) begin
        ecnt_d[i] = ecnt_d[i] + 1'b1;
      end
    end
  end

  // Registers of the counters.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ustat_q <= '0;
      for (int i = 0; i < NUM_UNITS; i++) begin
        ecnt_q[i] <= '0;
      end
    end else begin
      ustat_q <= ustat_d;
      for (int i = 0; i < NUM_UNITS; i++) begin
        ecnt_q[i] <= ecnt_d[i];
      end
    end
  end
  assign errcnt = ecnt_q;

  // Status word: fault state, counts, permissive, unit status.
  assign status_w = {2'h0, nflt_q, mins_q, 1'b0, PERM_FAULT,
                     fst_q == SFS_LATCHED, CRIT_FAULT, ustat_q[15:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Detector event filter and automatic reset timers.
  logic [NUM_DET-1:0] dev_d, drst;
  assign dev_d = (det_mode != SFS_DET_OFF) ?
                 (dflt_s2_q & ~dflt_s3_q & enable_q[NUM_TERM +: NUM_DET])
                 : '0;

  for (genvar g = 0; g < NUM_DET; g++) begin : g_det
    sfs_gap_timer #(
      .GAP_CYC (GAP_CYCLES)
    ) u_gap (
      .CLK_SYS (CLK_SYS),
      .RST_N   (RST_N),
      .enable  (run && det_mode == SFS_DET_RST &&
                enable_q[NUM_TERM + g]),
      .wdog    (wdog_s2_q[g]),
      .pulse   (drst[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, registered.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      UNIT_POLL_EN <= '0;
      TERM_LAYOUT  <= SFS_MAP_16;
      DET_EVENT    <= '0;
      DET_RESET    <= '0;
      CRIT_FAULT   <= 1'b0;
      PERM_FAULT   <= 1'b0;
      FLASH_REQ    <= 1'b0;
      MON_MAP      <= '0;
    end else begin
      UNIT_POLL_EN <= run ? enable_q : '0;
      TERM_LAYOUT  <= ctrl_q[CTRL_MAP_LO +: 2];
      DET_EVENT    <= dev_d;
      DET_RESET    <= drst;
      CRIT_FAULT   <= fst_q != SFS_OK;
      PERM_FAULT   <= enable_q[UNIT_MON] && (perm_q != card_s2_q);
      FLASH_REQ    <= enable_q[UNIT_MON] && (perm_q != card_s2_q);
      for (int c = 0; c < 16; c++) begin
        MON_MAP[c*5 +: 5] <= (mmap_q[c*5 +: 5] == 5'h0) ? 5'(c + 1)
                             : mmap_q[c*5 +: 5];
      end
    end
  end
endmodule : sfs_supervisor
